// file: hdl/nvpc_top.sv
// What this block does
// RL1 - flash split into 256-byte-block sections
// RL2 - zero fuses widen program or first section
// RL3 - writes only flow toward later sections
// RL4 - locks hold until the next reset
// RL5 - first section never CPU-written; lock blocks reads
// RL6 - eeprom touches only marked bytes
// RL7 - user row eeprom-like, debug writes when locked
// RL8 - array reads wait while busy
// RL9 - one shared buffer, low address bits index
// RL10 - store ANDs into buffer byte
// RL11 - buffer all ones after reset, op, clear, wake
// RL12 - software writes key then command quickly
// RL13 - page write, flash halts cpu
// RL14 - erase needs marked byte, flash halts
// RL15 - eeprom erase marked bytes, cpu runs
// RL16 - erase then write without buffer clear
// RL17 - buffer clear halts cpu seven cycles
// RL18 - full erase spares eeprom if fuse set
// RL19 - eeprom erase halts cpu until done
// RL20 - fuse write refused from the cpu
// RL21 - fuse uses address and data registers
// RL22 - reset aborts any running operation
// RL23 - three-bit command field decode
// RL24 - busy flags and last-op write error
// RL25 - eeprom ready flag, write-one clear, request
// RL26 - command field changes only after key
// RL27 - one mark bit per buffer byte
// RL28 - forbidden target leaves memory, flags error
//
// Added by the designer: register access over AXI4-Lite and the address map.
`include "nvpc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module nvpc_top #(
  parameter int PAGE_BYTES = `NVPC_PAGE_BYTES_DEF,
  parameter logic [15:0] FLASH_BASE = `NVPC_FLASH_BASE_DEF,
  parameter logic [15:0] EE_BASE = `NVPC_EE_BASE_DEF,
  parameter logic [15:0] EE_BYTES = `NVPC_EE_BYTES_DEF,
  parameter logic [15:0] USER_BASE = `NVPC_USER_BASE_DEF,
  parameter logic [15:0] USER_BYTES = `NVPC_USER_BYTES_DEF,
  localparam int IW = $clog2(PAGE_BYTES)
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] cpu_pc,
  input wire logic instr_retired,
  input wire logic store_valid,
  input wire logic [15:0] store_addr,
  input wire logic [7:0] store_data,
  input wire logic wake_pulse,
  input wire logic dbg_cmd_valid,
  input wire logic [2:0] dbg_cmd,
  input wire logic device_locked,
  input wire logic [7:0] first_section_end_fuse,
  input wire logic [7:0] program_section_end_fuse,
  input wire logic keep_eeprom_on_full_erase,
  input wire logic array_done,
  input wire logic [IW-1:0] pb_rd_idx,
  output logic [7:0] pb_rd_data_q,
  output logic pb_rd_mark_q,
  output logic op_req_q,
  output nvpc_pkg::nvpc_op_t op_kind_q,
  output nvpc_pkg::nvpc_tgt_t op_target_q,
  output logic [15:0] op_addr_q,
  output logic [7:0] op_data_q,
  output logic op_keep_ee_q,
  output logic cpu_halt_q,
  output logic load_wait_q,
  output logic first_read_block_q,
  output logic eeprom_ready_flag_irq_q
);
  if (PAGE_BYTES < 2 || (1 << IW) != PAGE_BYTES)
  begin : g_bad_page
    $error("PAGE_BYTES must be a power of two, at least 2");
  end

  nvpc_pkg::nvpc_state_t st_q;
  nvpc_pkg::nvpc_tgt_t tgt_q;
  logic [7:0] pb_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_q;
  logic [15:0] pb_addr_q, data_q, addr_q;
  logic [2:0] cmd_q, guard_q, clr_cnt_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q, mixed_q, erw_q, werr_q, fl_busy_q, ee_busy_q;
  logic pwlock_q, frlock_q, irq_en_q, eeprom_ready_flag_q;
  logic wr_go, rd_go, store_go, clear_now, cpu_fire, dbg_fire, fire, err, any_mark, page_cmd;
  logic [2:0] fire_cmd;
  logic [5:0] widx;
  nvpc_pkg::nvpc_sec_t src_sec, tgt_sec;

  // section of a flash byte offset from the two end fuses
  // RL1 block limits
  function automatic nvpc_pkg::nvpc_sec_t sec_of(input logic [15:0] off);
    logic [15:0] boot_lim;
    logic [15:0] app_lim;
    boot_lim = 16'(first_section_end_fuse) << `NVPC_BLOCK_SHIFT;
    app_lim = 16'(program_section_end_fuse) << `NVPC_BLOCK_SHIFT;
    // RL2 zero fuse cases
    if (first_section_end_fuse == '0 || off < boot_lim)
      return nvpc_pkg::SEC_FIRST;
    else if (program_section_end_fuse == '0 || off < app_lim)
      return nvpc_pkg::SEC_PROG;
    else
      return nvpc_pkg::SEC_DATA;
  endfunction

  function automatic nvpc_pkg::nvpc_tgt_t tgt_of(input logic [15:0] a);
    if (a >= EE_BASE && a < EE_BASE + EE_BYTES)
      return nvpc_pkg::TGT_EE;
    else if (a >= USER_BASE && a < USER_BASE + USER_BYTES)
      return nvpc_pkg::TGT_USER;
    else
      return nvpc_pkg::TGT_FLASH;
  endfunction

  // bus handshakes; one write and one read outstanding
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign widx = aw_q[7:2];
  assign store_go = store_valid && st_q == nvpc_pkg::ST_IDLE;
  assign clear_now = st_q == nvpc_pkg::ST_DONE || wake_pulse;
  assign any_mark = |mark_q;
  assign src_sec = sec_of(cpu_pc);
  assign tgt_sec = sec_of(pb_addr_q - FLASH_BASE);

  // command launch: cpu side needs open guard window
  // RL26 key gates field
  assign cpu_fire = wr_go && widx == `NVPC_IDX_CMDREG && ws_q[0] && guard_q != '0
                    && st_q == nvpc_pkg::ST_IDLE;
  assign dbg_fire = dbg_cmd_valid && !cpu_fire && st_q == nvpc_pkg::ST_IDLE;
  assign fire = cpu_fire || dbg_fire;
  assign fire_cmd = cpu_fire ? w_q[2:0] : dbg_cmd;
  assign page_cmd = fire_cmd == `NVPC_CMD_PW || fire_cmd == `NVPC_CMD_ERS || fire_cmd == `NVPC_CMD_ERW;

  // protection check evaluated at launch
  always_comb
  begin
    err = 1'b0;
    if (cpu_fire)
    begin
      // RL20 cpu fuse refused
      if (fire_cmd == `NVPC_CMD_FUSE)
        err = 1'b1;
      // RL3 directional protection
      if ((page_cmd || fire_cmd == `NVPC_CMD_FULL || fire_cmd == `NVPC_CMD_EE) && src_sec == nvpc_pkg::SEC_DATA)
        err = 1'b1;
      // RL5 first section closed
      if (page_cmd && tgt_q == nvpc_pkg::TGT_FLASH && (tgt_sec == nvpc_pkg::SEC_FIRST ||
          (tgt_sec == nvpc_pkg::SEC_PROG && (src_sec != nvpc_pkg::SEC_FIRST || pwlock_q))))
        err = 1'b1;
    end
    else if (dbg_fire && page_cmd)
    begin
      // RL7 user row open when locked
      err = device_locked && tgt_q != nvpc_pkg::TGT_USER;
    end
    // mixed-target buffer cannot be programmed
    if (fire && page_cmd && mixed_q)
      err = 1'b1;
  end

  // write channel capture, address and data in either order
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NVPC_RESP_OKAY;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx <= `NVPC_IDX_INTFLAGS || widx == `NVPC_IDX_DATA ||
                        widx == `NVPC_IDX_ADDR || widx == `NVPC_IDX_GUARD) ? `NVPC_RESP_OKAY : `NVPC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel, answer one cycle after address is taken
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `NVPC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `NVPC_RESP_OKAY;
      // RL24 status readback
      case (s_axi_araddr[7:2])
        `NVPC_IDX_CMDREG: s_axi_rdata <= 32'(cmd_q);
        `NVPC_IDX_LOCKREG: s_axi_rdata <= 32'({frlock_q, pwlock_q});
        `NVPC_IDX_STATUS: s_axi_rdata <= 32'({werr_q, ee_busy_q, fl_busy_q});
        `NVPC_IDX_INTCTRL: s_axi_rdata <= 32'(irq_en_q);
        `NVPC_IDX_INTFLAGS: s_axi_rdata <= 32'(eeprom_ready_flag_q);
        `NVPC_IDX_DATA: s_axi_rdata <= 32'(data_q);
        `NVPC_IDX_ADDR: s_axi_rdata <= 32'(addr_q);
        `NVPC_IDX_GUARD: s_axi_rdata <= 32'({guard_q != '0, 1'b0});
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `NVPC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software registers; locks only ever set
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwlock_q <= 1'b0;
      frlock_q <= 1'b0;
      irq_en_q <= 1'b0;
      data_q <= '0;
      addr_q <= '0;
      guard_q <= '0;
      first_read_block_q <= 1'b0;
    end
    else
    begin
      // guard window closes after the set number of instructions
      if (instr_retired && guard_q != '0)
        guard_q <= guard_q - 3'h1;
      if (wr_go && ws_q[0])
      begin
        case (widx)
          // RL4 sticky locks
          `NVPC_IDX_LOCKREG:
          begin
            pwlock_q <= pwlock_q | w_q[0];
            frlock_q <= frlock_q | (w_q[1] && src_sec == nvpc_pkg::SEC_FIRST);
          end
          `NVPC_IDX_INTCTRL: irq_en_q <= w_q[0];
          `NVPC_IDX_GUARD: if (w_q[7:0] == `NVPC_UNLOCK_KEY) guard_q <= `NVPC_GUARD_WINDOW;
          default: ;
        endcase
      end
      // RL21 fuse address and value
      if (wr_go && widx == `NVPC_IDX_DATA)
        data_q <= {ws_q[1] ? w_q[15:8] : data_q[15:8], ws_q[0] ? w_q[7:0] : data_q[7:0]};
      if (wr_go && widx == `NVPC_IDX_ADDR)
        addr_q <= {ws_q[1] ? w_q[15:8] : addr_q[15:8], ws_q[0] ? w_q[7:0] : addr_q[7:0]};
      // RL5 read lock applies once the cpu leaves the first section
      first_read_block_q <= frlock_q && src_sec != nvpc_pkg::SEC_FIRST;
    end
  end

  // ready flag: set wins over a write-one clear
  // RL25 sticky flag
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eeprom_ready_flag_q <= 1'b0;
      eeprom_ready_flag_irq_q <= 1'b0;
    end
    else
    begin
      eeprom_ready_flag_q <= (st_q == nvpc_pkg::ST_DONE && ee_busy_q) ||
                   (eeprom_ready_flag_q && !(wr_go && widx == `NVPC_IDX_INTFLAGS && ws_q[0] && w_q[0]));
      eeprom_ready_flag_irq_q <= eeprom_ready_flag_q && irq_en_q;
    end
  end

  // page buffer with a mark per byte; one buffer for every memory
  // RL11 reset to all ones
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        pb_q[i] <= '1;
      mark_q <= '0;
      mixed_q <= 1'b0;
      pb_addr_q <= '0;
      tgt_q <= nvpc_pkg::TGT_FLASH;
    end
    // RL11 clear after op or wake
    else if (clear_now)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        pb_q[i] <= '1;
      // RL27 marks cleared with buffer
      mark_q <= '0;
      mixed_q <= 1'b0;
    end
    else if (store_go)
    begin
      // RL10 AND merge
      // RL9 low bits index
      pb_q[store_addr[IW-1:0]] <= pb_q[store_addr[IW-1:0]] & store_data;
      // RL6 byte marked
      mark_q[store_addr[IW-1:0]] <= 1'b1;
      mixed_q <= mixed_q || (any_mark && tgt_of(store_addr) != tgt_q);
      pb_addr_q <= store_addr;
      tgt_q <= tgt_of(store_addr);
    end
  end

  // array side reads the buffer while an operation runs
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pb_rd_data_q <= '1;
      pb_rd_mark_q <= 1'b0;
    end
    else
    begin
      pb_rd_data_q <= pb_q[pb_rd_idx];
      pb_rd_mark_q <= mark_q[pb_rd_idx];
    end
  end

  // command sequencer; async reset drops any running request
  // RL22 reset aborts
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= nvpc_pkg::ST_IDLE;
      cmd_q <= `NVPC_CMD_NONE;
      op_req_q <= 1'b0;
      op_kind_q <= nvpc_pkg::OP_PAGE_WRITE;
      op_target_q <= nvpc_pkg::TGT_FLASH;
      op_addr_q <= '0;
      op_data_q <= '0;
      op_keep_ee_q <= 1'b0;
      erw_q <= 1'b0;
      clr_cnt_q <= '0;
      werr_q <= 1'b0;
      fl_busy_q <= 1'b0;
      ee_busy_q <= 1'b0;
      cpu_halt_q <= 1'b0;
      load_wait_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        nvpc_pkg::ST_IDLE:
          if (fire && fire_cmd != `NVPC_CMD_NONE)
          begin
            // RL24 error of last op
            // RL28 refused op untouched
            werr_q <= err;
            if (!err)
            begin
              cmd_q <= fire_cmd;
              op_target_q <= tgt_q;
              op_addr_q <= pb_addr_q;
              op_keep_ee_q <= keep_eeprom_on_full_erase;
              // RL23 command decode
              case (fire_cmd)
                `NVPC_CMD_PW, `NVPC_CMD_ERS, `NVPC_CMD_ERW:
                  // RL14 erase needs a mark
                  if (fire_cmd != `NVPC_CMD_ERS || any_mark)
                  begin
                    st_q <= fire_cmd == `NVPC_CMD_PW ? nvpc_pkg::ST_WRITE : nvpc_pkg::ST_ERASE;
                    op_kind_q <= fire_cmd == `NVPC_CMD_PW ? nvpc_pkg::OP_PAGE_WRITE : nvpc_pkg::OP_PAGE_ERASE;
                    // RL16 erase then write
                    erw_q <= fire_cmd == `NVPC_CMD_ERW;
                    op_req_q <= 1'b1;
                    // RL8 array loads stall
                    load_wait_q <= 1'b1;
                    fl_busy_q <= tgt_q == nvpc_pkg::TGT_FLASH;
                    ee_busy_q <= tgt_q != nvpc_pkg::TGT_FLASH;
                    // RL13 flash halts, eeprom runs
                    // RL15 eeprom erase runs
                    cpu_halt_q <= tgt_q == nvpc_pkg::TGT_FLASH;
                  end
                  else
                    cmd_q <= `NVPC_CMD_NONE;
                // RL17 seven-cycle clear
                `NVPC_CMD_CLR:
                begin
                  st_q <= nvpc_pkg::ST_CLEAR;
                  clr_cnt_q <= `NVPC_CLEAR_CYCLES;
                  cpu_halt_q <= 1'b1;
                end
                // RL18 keep fuse passed on
                // RL19 eeprom erase halts
                `NVPC_CMD_FULL, `NVPC_CMD_EE:
                begin
                  st_q <= nvpc_pkg::ST_ERASE;
                  op_kind_q <= fire_cmd == `NVPC_CMD_FULL ? nvpc_pkg::OP_FULL_ERASE : nvpc_pkg::OP_EE_ERASE;
                  op_req_q <= 1'b1;
                  load_wait_q <= 1'b1;
                  fl_busy_q <= fire_cmd == `NVPC_CMD_FULL;
                  ee_busy_q <= fire_cmd == `NVPC_CMD_EE || !keep_eeprom_on_full_erase;
                  cpu_halt_q <= 1'b1;
                end
                default:
                begin
                  st_q <= nvpc_pkg::ST_WRITE;
                  op_kind_q <= nvpc_pkg::OP_FUSE_WRITE;
                  op_addr_q <= addr_q;
                  op_data_q <= data_q[7:0];
                  op_req_q <= 1'b1;
                  load_wait_q <= 1'b1;
                  fl_busy_q <= 1'b1;
                  cpu_halt_q <= 1'b1;
                end
              endcase
            end
          end
        nvpc_pkg::ST_ERASE:
          if (array_done)
          begin
            // buffer kept between the two halves
            if (erw_q)
            begin
              st_q <= nvpc_pkg::ST_WRITE;
              op_kind_q <= nvpc_pkg::OP_PAGE_WRITE;
              erw_q <= 1'b0;
            end
            else
            begin
              st_q <= nvpc_pkg::ST_DONE;
              op_req_q <= 1'b0;
            end
          end
        nvpc_pkg::ST_WRITE:
          if (array_done)
          begin
            st_q <= nvpc_pkg::ST_DONE;
            op_req_q <= 1'b0;
          end
        nvpc_pkg::ST_CLEAR:
        begin
          clr_cnt_q <= clr_cnt_q - 3'h1;
          if (clr_cnt_q == 3'h1)
          begin
            st_q <= nvpc_pkg::ST_DONE;
            cpu_halt_q <= 1'b0;
          end
        end
        nvpc_pkg::ST_DONE:
        begin
          st_q <= nvpc_pkg::ST_IDLE;
          cmd_q <= `NVPC_CMD_NONE;
          fl_busy_q <= 1'b0;
          ee_busy_q <= 1'b0;
          cpu_halt_q <= 1'b0;
          load_wait_q <= 1'b0;
        end
        default: st_q <= nvpc_pkg::ST_IDLE;
      endcase
    end
  end

  // helpers for the checks below
  logic chk_q;
  logic [IW-1:0] chk_idx_q;
  logic [7:0] chk_ref_q;
  logic pb_ones;
  always_comb
  begin
    pb_ones = 1'b1;
    for (int i = 0; i < PAGE_BYTES; i++)
      pb_ones = pb_ones && pb_q[i] == 8'hFF;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chk_q <= 1'b0;
      chk_idx_q <= '0;
      chk_ref_q <= '0;
    end
    else
    begin
      chk_q <= store_go && !clear_now;
      chk_idx_q <= store_addr[IW-1:0];
      chk_ref_q <= pb_q[store_addr[IW-1:0]] & store_data;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_and_merge;
    chk_q |-> pb_q[chk_idx_q] == chk_ref_q;
  endproperty
  a_and_merge: assert property (p_and_merge) else $error("buffer store did not AND merge"); // RL10

  property p_clear_after_op;
    st_q == nvpc_pkg::ST_DONE |=> pb_ones && !any_mark;
  endproperty
  a_clear_after_op: assert property (p_clear_after_op) else $error("buffer not all ones after op"); // RL11

  property p_clear_halt;
    $rose(st_q == nvpc_pkg::ST_CLEAR) |-> cpu_halt_q [*7] ##1 !cpu_halt_q;
  endproperty
  a_clear_halt: assert property (p_clear_halt) else $error("buffer clear halt not seven cycles"); // RL17

  property p_locks_hold;
    (pwlock_q |=> pwlock_q) and (frlock_q |=> frlock_q);
  endproperty
  a_locks_hold: assert property (p_locks_hold) else $error("lock bit dropped without reset"); // RL4

  property p_no_key;
    wr_go && widx == `NVPC_IDX_CMDREG && guard_q == '0 && st_q == nvpc_pkg::ST_IDLE |=> $stable(cmd_q) && !op_req_q;
  endproperty
  a_no_key: assert property (p_no_key) else $error("command taken without key"); // RL26

  property p_load_wait;
    op_req_q |-> load_wait_q;
  endproperty
  a_load_wait: assert property (p_load_wait) else $error("array busy without load wait"); // RL8

  property p_empty_erase;
    fire && fire_cmd == `NVPC_CMD_ERS && !any_mark |=> !op_req_q && st_q == nvpc_pkg::ST_IDLE;
  endproperty
  a_empty_erase: assert property (p_empty_erase) else $error("erase ran with empty buffer"); // RL14

  property p_cpu_fuse;
    cpu_fire && fire_cmd == `NVPC_CMD_FUSE |=> werr_q && !op_req_q;
  endproperty
  a_cpu_fuse: assert property (p_cpu_fuse) else $error("cpu started fuse write"); // RL20

  property p_flash_halt;
    op_req_q && op_target_q == nvpc_pkg::TGT_FLASH && op_kind_q != nvpc_pkg::OP_FUSE_WRITE |-> cpu_halt_q;
  endproperty
  a_flash_halt: assert property (p_flash_halt) else $error("flash op without cpu halt"); // RL13

  property p_irq;
    eeprom_ready_flag_q && irq_en_q |=> eeprom_ready_flag_irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("ready interrupt not raised"); // RL25

  c_erase_write: cover property (st_q == nvpc_pkg::ST_ERASE && erw_q && array_done);
  c_clear: cover property (st_q == nvpc_pkg::ST_CLEAR && clr_cnt_q == 3'h1);
  c_ee_ready: cover property ($rose(eeprom_ready_flag_q));
  c_fuse: cover property (dbg_fire && fire_cmd == `NVPC_CMD_FUSE);
endmodule
`default_nettype wire

// file: hdl/nvpc_defines.svh
`ifndef NVPC_DEFINES_SVH
`define NVPC_DEFINES_SVH
// register indices, byte address is index times four
`define NVPC_IDX_CMDREG 6'h00
`define NVPC_IDX_LOCKREG 6'h01
`define NVPC_IDX_STATUS 6'h02
`define NVPC_IDX_INTCTRL 6'h03
`define NVPC_IDX_INTFLAGS 6'h04
`define NVPC_IDX_DATA 6'h06
`define NVPC_IDX_ADDR 6'h08
`define NVPC_IDX_GUARD 6'h0A
// command codes
`define NVPC_CMD_NONE 3'h0
`define NVPC_CMD_PW 3'h1
`define NVPC_CMD_ERS 3'h2
`define NVPC_CMD_ERW 3'h3
`define NVPC_CMD_CLR 3'h4
`define NVPC_CMD_FULL 3'h5
`define NVPC_CMD_EE 3'h6
`define NVPC_CMD_FUSE 3'h7
// guard key and window length in retired instructions
`define NVPC_UNLOCK_KEY 8'h9D
`define NVPC_GUARD_WINDOW 3'h4
// buffer clear runs this many cycles
`define NVPC_CLEAR_CYCLES 3'h7
`define NVPC_BLOCK_SHIFT 8
// default memory map
`define NVPC_FLASH_BASE_DEF 16'h8000
`define NVPC_EE_BASE_DEF 16'h1400
`define NVPC_EE_BYTES_DEF 16'h0080
`define NVPC_USER_BASE_DEF 16'h1300
`define NVPC_USER_BYTES_DEF 16'h0020
`define NVPC_PAGE_BYTES_DEF 64
`define NVPC_RESP_OKAY 2'h0
`define NVPC_RESP_SLVERR 2'h2
`endif

// file: hdl/nvpc_pkg.sv
`include "nvpc_defines.svh"
package nvpc_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_ERASE = 3'h1, ST_WRITE = 3'h3, ST_DONE = 3'h2,
                            ST_CLEAR = 3'h6} nvpc_state_t;
  typedef enum logic [1:0] {SEC_FIRST, SEC_PROG, SEC_DATA} nvpc_sec_t;
  typedef enum logic [1:0] {TGT_FLASH, TGT_EE, TGT_USER} nvpc_tgt_t;
  typedef enum logic [2:0] {OP_PAGE_WRITE, OP_PAGE_ERASE, OP_FULL_ERASE, OP_EE_ERASE,
                            OP_FUSE_WRITE} nvpc_op_t;
endpackage

// file: sim/nvpc_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module nvpc_array_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic op_req,
  input wire logic [3:0] lat,
  output logic array_done
);
  logic [3:0] cnt_q;
  // each phase ends lat plus one cycles after the request; long lat keeps the op running
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 4'h0;
      array_done <= 1'b0;
    end
    else if (!op_req || array_done)
    begin
      cnt_q <= 4'h0;
      array_done <= 1'b0;
    end
    else if (cnt_q == lat)
      array_done <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
`include "nvpc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, dbg_v = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, instr_retired = 1'b0, store_valid = 1'b0, wake_pulse = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, store_data = 8'h00;
  logic [7:0] first_section_end_fuse = 8'h01, program_section_end_fuse = 8'h02;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hF, lat = 4'h2;
  logic [15:0] cpu_pc = 16'h0000, store_addr = 16'h0000, op_addr_q;
  logic [5:0] pb_rd_idx = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, array_done, op_req_q;
  logic op_keep_ee_q, pb_rd_mark_q, cpu_halt_q, load_wait_q, first_read_block_q, eeprom_ready_flag_irq_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [7:0] pb_rd_data_q, op_data_q;
  nvpc_pkg::nvpc_op_t op_kind_q;
  nvpc_pkg::nvpc_tgt_t op_target_q;
  int failures = 0, compares = 0, seed = 94, n;
  int pb_m [64];
  int mk_m [64];
  nvpc_top uut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_pc, .instr_retired,
    .store_valid, .store_addr, .store_data, .wake_pulse, .dbg_cmd_valid(dbg_v), .dbg_cmd(3'h7),
    .device_locked(1'b0), .first_section_end_fuse, .program_section_end_fuse, .keep_eeprom_on_full_erase(1'b0),
    .array_done, .pb_rd_idx, .pb_rd_data_q, .pb_rd_mark_q, .op_req_q, .op_kind_q, .op_target_q, .op_addr_q,
    .op_data_q, .op_keep_ee_q, .cpu_halt_q, .load_wait_q, .first_read_block_q, .eeprom_ready_flag_irq_q);
  nvpc_array_model far (.core_clk, .rstn, .op_req(op_req_q), .lat, .array_done);
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bus master: each channel released only at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // key first, then the command while the guard window is open
  // key then command
  task automatic cmd(input logic [2:0] c);
    wr(8'(`NVPC_IDX_GUARD * 4), {24'h0, `NVPC_UNLOCK_KEY});
    wr(8'h00, {29'h0, c});
  endtask
  // random stores into a program-section page, model ANDs and marks
  task automatic fill(input int k);
    logic [5:0] i;
    logic [7:0] d;
    repeat (k)
    begin
      i = 6'($random(seed));
      d = 8'($random(seed));
      store_valid <= 1'b1;
      store_addr <= `NVPC_FLASH_BASE_DEF + 16'h0100 + 16'(i);
      store_data <= d;
      @(posedge core_clk);
      pb_m[i] = pb_m[i] & int'(d);
      mk_m[i] = 1;
    end
    store_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic clear_m;
    foreach (pb_m[i])
    begin
      pb_m[i] = 255;
      mk_m[i] = 0;
    end
  endtask
  task automatic chk_buf;
    foreach (pb_m[i])
    begin
      pb_rd_idx <= 6'(i);
      repeat (2) @(posedge core_clk);
      chk(pb_rd_data_q, 32'(pb_m[i]));
      chk(pb_rd_mark_q, 32'(mk_m[i]));
    end
  endtask
  task automatic wait_idle;
    n = 0;
    while (op_req_q !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask
  // hang guard, far beyond the roughly one thousand cycles expected
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim;
  end
  // main sequence
  initial
  begin
    clear_m;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    chk_buf;
    rd(8'h08);
    chk(rd_v, 32'h0);
    fill(40);
    chk_buf;
    wake_pulse <= 1'b1;
    @(posedge core_clk);
    wake_pulse <= 1'b0;
    clear_m;
    chk_buf;
    // unkeyed command with the guard window never opened does nothing
    fill(8);
    instr_retired <= 1'b1;
    repeat (5) @(posedge core_clk);
    instr_retired <= 1'b0;
    wr(8'h00, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(op_req_q, 32'h0);
    // flash page write halts the cpu and stalls array reads
    lat <= 4'h8 + 4'($random(seed) & 7);
    cmd(`NVPC_CMD_PW);
    chk(op_req_q, 32'h1);
    chk(op_kind_q, nvpc_pkg::OP_PAGE_WRITE);
    chk(op_target_q, nvpc_pkg::TGT_FLASH);
    chk(op_addr_q[15:8], 32'h81);
    chk(cpu_halt_q, 32'h1);
    chk(load_wait_q, 32'h1);
    rstn <= 1'b0;
    @(posedge core_clk);
    chk(op_req_q, 32'h0);
    rstn <= 1'b1;
    clear_m;
    chk_buf;
    // erase then write keeps the request across both phases
    lat <= 4'h1 + 4'($random(seed) & 3);
    fill(6);
    cmd(`NVPC_CMD_ERW);
    chk(op_kind_q, nvpc_pkg::OP_PAGE_ERASE);
    wait_idle;
    clear_m;
    chk_buf;
    // buffer clear holds the cpu for its fixed span
    fill(4);
    cmd(`NVPC_CMD_CLR);
    n = 0;
    while (cpu_halt_q === 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk);
    end
    chk(n, 32'h7);
    clear_m;
    chk_buf;
    cmd(`NVPC_CMD_FUSE);
    chk(op_req_q, 32'h0);
    rd(8'h08);
    chk(rd_v[2], 32'h1);
    rd(8'h14);
    chk(rd_r, 32'(`NVPC_RESP_SLVERR));
    chk(first_read_block_q, 32'h0);
    // debug port may start the fuse write
    dbg_v <= 1'b1;
    @(posedge core_clk);
    dbg_v <= 1'b0;
    @(posedge core_clk);
    chk(op_kind_q, nvpc_pkg::OP_FUSE_WRITE);
    chk(op_data_q, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
